//--- pkg/clock_gate_if.sv
// Carries clock-domain gate enables from sequencer to gate unit.
// Assumes both ends sit on clock_i.
`timescale 1ns/10ps
interface clock_gate_if;
   logic run;          // Core out of reset
   logic core_halt;    // Sleep halts core
   logic periph_halt;  // Sleep halts peripherals
   logic conv_halt;    // Sleep halts converter
   logic sys_tick;     // Divided system tick
   modport seq (output run, core_halt, periph_halt, conv_halt, sys_tick);
   modport gate (input run, core_halt, periph_halt, conv_halt, sys_tick);
endinterface

//--- pkg/clock_startup_pkg.sv
// Constants for clock source selection and start-up sequencing.
// Assumes a single 100 MHz system clock; oscillators arrive as tick inputs.
package clock_startup_pkg;
   // System clock rate
   localparam int CLOCK_HZ = 100000000;
   // Fuse widths
   localparam int SEL_W = 4;
   localparam int SUT_W = 2;
   // Delivered fuse values
   localparam logic [3:0] SEL_DEFAULT = 4'h2;
   localparam logic [1:0] SUT_DEFAULT = 2'h2;
   localparam logic DIV8_DEFAULT = 1'h0;
   // Source codes
   localparam logic [3:0] SEL_EXT_CLOCK = 4'h0;
   localparam logic [3:0] SEL_RESERVED = 4'h1;
   localparam logic [3:0] SEL_RC_CAL = 4'h2;
   localparam logic [3:0] SEL_RC_128K = 4'h3;
   // Time-out lengths in watchdog-oscillator cycles
   localparam logic [13:0] TOUT_NONE = 14'h0000;
   localparam logic [13:0] TOUT_SHORT = 14'h0200;
   localparam logic [13:0] TOUT_LONG = 14'h2000;
   // Oscillator stabilisation counts
   localparam logic [15:0] OSC_EXT = 16'h0006;
   localparam logic [15:0] OSC_258 = 16'h0102;
   localparam logic [15:0] OSC_1K = 16'h0400;
   localparam logic [15:0] OSC_16K = 16'h4000;
   localparam logic [15:0] OSC_32K = 16'h8000;
   // Divider
   localparam logic [2:0] DIV8_LAST = 3'h7;
   // Selected oscillator kind
   typedef enum logic [2:0] {
      SRC_EXT = 3'b000,
      SRC_LOWPWR = 3'b001,
      SRC_FULLSWING = 3'b010,
      SRC_LOWFREQ = 3'b011,
      SRC_RC128 = 3'b100,
      SRC_RCCAL = 3'b101,
      SRC_NONE = 3'b110
   } source_t;
   // Start-up sequencer states
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_TIMEOUT = 2'b01,
      ST_OSC = 2'b10,
      ST_RUN = 2'b11
   } seq_state_t;
endpackage

//--- rtl/clock_domain_gates.sv
// Produces per-domain clock enables from the divided system tick; the async timer enable follows async_tick_i.
// Assumes the sequencer drives the gate interface on clock_i.
`timescale 1ns/10ps
module clock_domain_gates
   import clock_startup_pkg::*;
(
   input wire logic clock_i,      // System clock
   input wire logic reset_i,      // Async reset, high
   clock_gate_if.gate gif,        // Gate controls
   input wire logic async_tick_i, // Async timer source tick
   output logic core_en_o,        // Core clock enable
   output logic periph_en_o,      // Peripheral clock enable
   output logic progmem_en_o,     // Program memory enable
   output logic async_en_o,       // Async timer enable
   output logic conv_en_o         // Converter enable
);
   // Gate terms
   wire core_go = gif.sys_tick & gif.run & ~gif.core_halt;
   wire per_go = gif.sys_tick & gif.run & ~gif.periph_halt;
   wire conv_go = gif.sys_tick & gif.run & ~gif.conv_halt;

   // Registered enables; async timer never halted by sleep
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         core_en_o <= 1'b0;
         periph_en_o <= 1'b0;
         progmem_en_o <= 1'b0;
         async_en_o <= 1'b0;
         conv_en_o <= 1'b0;
      end else begin
         core_en_o <= core_go;      // RULE11
         periph_en_o <= per_go;     // RULE12
         progmem_en_o <= core_go;   // RULE13
         async_en_o <= async_tick_i; // RULE14
         conv_en_o <= conv_go;      // RULE15
      end
   end
endmodule

//--- rtl/clock_source_select_startup.sv
// Clock source decode, divide-by-eight and reset start-up sequencing.
// Assumes oscillator and watchdog ticks are one-cycle pulses on clock_i.
//
// Notes on behaviour
// RULE1 - Codes 1111-0100 pick crystal oscillators
// RULE2 - 0011 RC128, 0010 RC cal, 0000 external
// RULE3 - Fuse bit one unprogrammed, zero programmed
// RULE4 - Delivered: RC cal, divide-by-eight, STARTUP_TIME_FUSES 10
// RULE5 - Hold internal reset for watchdog time-out
// RULE6 - Time-out lengths 0, 512, 8192 cycles
// RULE7 - Oscillator cycle count then release reset
// RULE8 - Stabilisation count 6 to 32K by type
// RULE9 - Wake from sleep: oscillator count only
// RULE10 - Time-out counts only, senses no supply
// RULE11 - Core clock gated by sleep halts core
// RULE12 - Peripheral clock gated; async wake stays
// RULE13 - Program memory clock follows core clock
// RULE14 - Async timer domain runs during sleep
// RULE15 - Converter domain runs while core halted
// RULE16 - Programmed divide fuse divides by eight
// RULE17 - Zero time-out goes straight to count
`timescale 1ns/10ps
module clock_source_select_startup
   import clock_startup_pkg::*;
#(
   parameter int TOUT_W = 14, // Time-out counter width
   parameter int OSC_W = 16   // Stabilisation counter width
) (
   input wire logic clock_i,            // System clock
   input wire logic reset_i,            // Async reset, high
   input wire logic [3:0] clock_source_select_fuses_i, // Source fuses
   input wire logic [1:0] startup_time_fuses_i, // Start-up fuses
   input wire logic divide_by_eight_fuse_i, // Zero means divide
   input wire logic ext_reset_hold_i,   // Other reset sources active
   input wire logic wake_i,             // Wake from deep sleep pulse
   input wire logic deep_sleep_i,       // Power-save/down entered
   input wire logic core_halt_i,        // Sleep halts core
   input wire logic periph_halt_i,      // Sleep halts peripherals
   input wire logic conv_halt_i,        // Sleep halts converter
   input wire logic watchdog_tick_i,    // Watchdog oscillator tick
   input wire logic osc_tick_i,         // Selected oscillator tick
   input wire logic async_tick_i,       // Async timer source tick
   output logic internal_reset_o,       // Internal reset, high
   output source_t source_o,            // Decoded source kind
   output logic source_valid_o,         // Source code not reserved
   output logic core_en_o,              // Core clock enable
   output logic periph_en_o,            // Peripheral clock enable
   output logic progmem_en_o,           // Program memory enable
   output logic async_en_o,             // Async timer enable
   output logic conv_en_o               // Converter enable
);
   // Fuse bits read as programmed when zero
   function automatic logic programmed(input logic bit_in);
      return ~bit_in; // RULE3
   endfunction

   // Decode source kind from fuse code
   function automatic source_t decode_source(input logic [3:0] code);
      if (code[3]) return SRC_LOWPWR;                   // RULE1
      else if (code[2:1] == 2'b11) return SRC_FULLSWING; // RULE1
      else if (code[2:1] == 2'b10) return SRC_LOWFREQ;   // RULE1
      else if (code == SEL_RC_128K) return SRC_RC128;    // RULE2
      else if (code == SEL_RC_CAL) return SRC_RCCAL;     // RULE2
      else if (code == SEL_EXT_CLOCK) return SRC_EXT;    // RULE2
      else return SRC_NONE;
   endfunction

   clock_gate_if gif ();

   source_t state_src;
   seq_state_t state_reg, state_next;
   logic [TOUT_W-1:0] tout_cnt_reg, tout_cnt_next;
   logic [OSC_W-1:0] osc_cnt_reg, osc_cnt_next;
   logic [2:0] div_reg;       // Divide-by-eight prescaler
   logic tick_reg;            // Divided system tick

   // Decoded fuses
   assign state_src = decode_source(clock_source_select_fuses_i);
   wire div_on = programmed(divide_by_eight_fuse_i);
   wire [1:0] startup_time_fuses = startup_time_fuses_i;
   wire sel0 = clock_source_select_fuses_i[0];

   // Time-out length: STARTUP_TIME_FUSES 00 none-class, 01 short, 1x long for non-low-power sources; zero if
   // brown-out class option chosen (STARTUP_TIME_FUSES 10 on ceramic, 01 on crystal).
   // Only a cycle count: nothing here looks at supply level.
   wire bod_class = (state_src == SRC_LOWPWR) ?
      ((!sel0 && startup_time_fuses == 2'b10) || (sel0 && startup_time_fuses == 2'b01)) :
      (startup_time_fuses == 2'b00);
   wire short_class = (state_src == SRC_LOWPWR) ?
      ((!sel0 && startup_time_fuses == 2'b00) || (!sel0 && startup_time_fuses == 2'b11) ||
       (sel0 && startup_time_fuses == 2'b10)) :
      (startup_time_fuses == 2'b01);
   wire [TOUT_W-1:0] tout_len = bod_class ? TOUT_W'(TOUT_NONE) :
      short_class ? TOUT_W'(TOUT_SHORT) : TOUT_W'(TOUT_LONG); // RULE6
   wire tout_zero = (tout_len == '0);

   // Stabilisation count by clock type
   wire lp_short = !sel0 && (startup_time_fuses[1] == 1'b0);
   wire lp_mid = (!sel0 && startup_time_fuses[1]) || (sel0 && startup_time_fuses == 2'b00);
   wire [OSC_W-1:0] osc_len =
      (state_src == SRC_EXT) ? OSC_W'(OSC_EXT) :
      (state_src == SRC_LOWFREQ) ? OSC_W'(OSC_32K) :
      (state_src == SRC_LOWPWR || state_src == SRC_FULLSWING) ?
         (lp_short ? OSC_W'(OSC_258) :
          lp_mid ? OSC_W'(OSC_1K) : OSC_W'(OSC_16K)) :
      OSC_W'(OSC_EXT); // RULE8

   // Counter end flags
   wire tout_done = watchdog_tick_i && (tout_cnt_reg == tout_len - 1'b1);
   wire osc_done = osc_tick_i && (osc_cnt_reg == osc_len - 1'b1);

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      tout_cnt_next = tout_cnt_reg;
      osc_cnt_next = osc_cnt_reg;
      unique case (state_reg)
         ST_HOLD: begin
            // Wait for every other reset source to release
            tout_cnt_next = '0;
            osc_cnt_next = '0;
            if (!ext_reset_hold_i) begin
               if (tout_zero) begin
                  state_next = ST_OSC;     // RULE17
               end else begin
                  state_next = ST_TIMEOUT; // RULE5
               end
            end
         end
         ST_TIMEOUT: begin
            // Count watchdog ticks
            if (watchdog_tick_i) begin
               tout_cnt_next = tout_cnt_reg + 1'b1; // RULE5 RULE10
            end
            if (tout_done) begin
               state_next = ST_OSC; // RULE7
            end
         end
         ST_OSC: begin
            // Synchronous count of oscillator cycles
            if (osc_tick_i) begin
               osc_cnt_next = osc_cnt_reg + 1'b1; // RULE7
            end
            if (osc_done) begin
               state_next = ST_RUN; // RULE7
            end
         end
         ST_RUN: begin
            // Deep sleep: wake applies only oscillator count
            if (deep_sleep_i && wake_i) begin
               osc_cnt_next = '0;
               state_next = ST_OSC; // RULE9
            end
         end
      endcase
      if (ext_reset_hold_i) begin
         state_next = ST_HOLD;
      end
   end

   // Sequencer registers
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_HOLD;
         tout_cnt_reg <= '0;
         osc_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         tout_cnt_reg <= tout_cnt_next;
         osc_cnt_reg <= osc_cnt_next;
      end
   end

   // Divide selected source by eight when fuse programmed
   wire div_wrap = (div_reg == DIV8_LAST);
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         if (osc_tick_i) begin
            div_reg <= div_wrap ? 3'h0 : div_reg + 3'h1; // RULE16
         end
         tick_reg <= osc_tick_i && (!div_on || div_wrap); // RULE16
      end
   end

   // Registered status outputs
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         internal_reset_o <= 1'b1;
         source_o <= SRC_RCCAL; // RULE4
         source_valid_o <= 1'b0;
      end else begin
         internal_reset_o <= (state_next != ST_RUN); // RULE7
         source_o <= state_src;
         source_valid_o <= (state_src != SRC_NONE);
      end
   end

   // Gate controls to the domain unit
   assign gif.run = (state_reg == ST_RUN);
   assign gif.core_halt = core_halt_i;
   assign gif.periph_halt = periph_halt_i;
   assign gif.conv_halt = conv_halt_i;
   assign gif.sys_tick = tick_reg;

   clock_domain_gates u_gates (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .gif(gif),
      .async_tick_i(async_tick_i),
      .core_en_o(core_en_o),
      .periph_en_o(periph_en_o),
      .progmem_en_o(progmem_en_o),
      .async_en_o(async_en_o),
      .conv_en_o(conv_en_o)
   );
endmodule

//--- testbench/clock_source_select_startup_asserts.sv
// Port checks for the clock start-up block.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/10ps
module clock_source_select_startup_asserts
   import clock_startup_pkg::*;
#(
   parameter int TOUT_W = 14, // Time-out width
   parameter int OSC_W = 16   // Count width
) (
   input wire logic clock_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic [3:0] clock_source_select_fuses_i, // Fuses
   input wire logic divide_by_eight_fuse_i, // Divide fuse
   input wire logic ext_reset_hold_i, // Other resets
   input wire logic wake_i, // Wake
   input wire logic deep_sleep_i, // Deep sleep
   input wire logic core_halt_i, // Core halt
   input wire logic periph_halt_i, // Periph halt
   input wire logic osc_tick_i, // Osc tick
   input wire logic async_tick_i, // Async tick
   input wire logic internal_reset_o, // Internal reset
   input wire source_t source_o, // Source
   input wire logic source_valid_o, // Valid code
   input wire logic core_en_o, // Core enable
   input wire logic periph_en_o, // Periph enable
   input wire logic progmem_en_o, // Progmem enable
   input wire logic async_en_o // Async enable
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Expected kind; bit 3 alone marks the low-power crystal
   function automatic source_t exp_src(input logic [3:0] f);
      return f[3] ? SRC_LOWPWR : (f[2:1] == 2'h3) ? SRC_FULLSWING :
         (f[2:1] == 2'h2) ? SRC_LOWFREQ : (f == SEL_RC_128K) ? SRC_RC128 :
         (f == SEL_RC_CAL) ? SRC_RCCAL : (f == SEL_EXT_CLOCK) ? SRC_EXT :
         SRC_NONE;
   endfunction
   // Three cycles of halt cover the enable pipeline
   sequence core_halted_s; core_halt_i [*3]; endsequence
   sequence periph_halted_s; periph_halt_i [*3]; endsequence
   sequence divided_s; (!divide_by_eight_fuse_i) [*3] ##0 core_en_o; endsequence
   a_source_decode: assert property (!$past(reset_i) |->
      source_o == exp_src($past(clock_source_select_fuses_i)))
      else $error("source decode wrong");
   a_reserved_flag: assert property (!$past(reset_i) |->
      source_valid_o == ($past(clock_source_select_fuses_i) != SEL_RESERVED))
      else $error("valid flag wrong");
   a_hold_keeps_reset: assert property (ext_reset_hold_i |=>
      internal_reset_o) else $error("reset not held");
   a_release_on_tick: assert property ($fell(internal_reset_o) |->
      $past(osc_tick_i)) else $error("release without osc tick");
   a_wake_reapplies: assert property (!internal_reset_o && deep_sleep_i &&
      wake_i |=> internal_reset_o) else $error("wake kept running");
   a_core_halt_stops: assert property (core_halted_s |=>
      !core_en_o) else $error("core enable while halted");
   a_periph_halt_stops: assert property (periph_halted_s |=>
      !periph_en_o) else $error("periph enable while halted");
   a_progmem_follows: assert property (progmem_en_o == core_en_o)
      else $error("progmem enable differs");
   a_async_free: assert property (!$past(reset_i) |->
      async_en_o == $past(async_tick_i)) else $error("async enable wrong");
   a_divided_spacing: assert property (divided_s |=> (!core_en_o) [*8])
      else $error("divided enable too close");
endmodule
bind clock_source_select_startup clock_source_select_startup_asserts #(
   .TOUT_W(TOUT_W), .OSC_W(OSC_W)) i_clock_source_select_startup_asserts (
   .clock_i(clock_i), .reset_i(reset_i), .wake_i(wake_i),
   .clock_source_select_fuses_i(clock_source_select_fuses_i),
   .divide_by_eight_fuse_i(divide_by_eight_fuse_i),
   .ext_reset_hold_i(ext_reset_hold_i), .deep_sleep_i(deep_sleep_i),
   .core_halt_i(core_halt_i), .periph_halt_i(periph_halt_i),
   .osc_tick_i(osc_tick_i), .async_tick_i(async_tick_i),
   .internal_reset_o(internal_reset_o), .source_o(source_o),
   .source_valid_o(source_valid_o), .core_en_o(core_en_o),
   .periph_en_o(periph_en_o), .progmem_en_o(progmem_en_o),
   .async_en_o(async_en_o));

//--- testbench/clock_source_select_startup_tb.sv
// Self-checking bench for the clock start-up block.
// Assumes the tick model drives all oscillator inputs.
`timescale 1ns/10ps
module clock_source_select_startup_tb import clock_startup_pkg::*;;
   logic clock_i = 1'b0, reset_i = 1'b1; // Clock and reset
   logic [3:0] sel = SEL_DEFAULT; // Source fuses
   logic [1:0] start_fuses = SUT_DEFAULT; // Start-up fuses
   logic div_fuse = DIV8_DEFAULT, ext_hold = 1'b1; // Divide, hold
   logic wake = 1'b0, deep_sleep = 1'b0, core_halt = 1'b0; // Sleep
   logic periph_halt = 1'b0, conv_halt = 1'b0; // Halts
   logic wd_tick, osc_tick, async_tick, int_reset, valid; // Ticks
   logic core_en, periph_en, conv_en; // Enables
   source_t source; // Decoded kind
   int num_errors = 0, cmp_count = 0; // Tallies
   source_t kinds[16] = '{SRC_EXT, SRC_NONE, SRC_RCCAL, SRC_RC128,
      SRC_LOWFREQ, SRC_LOWFREQ, SRC_FULLSWING, SRC_FULLSWING, SRC_LOWPWR,
      SRC_LOWPWR, SRC_LOWPWR, SRC_LOWPWR, SRC_LOWPWR, SRC_LOWPWR,
      SRC_LOWPWR, SRC_LOWPWR}; // Expected per code
   clock_source_select_startup i_clock_source_select_startup (
      .clock_i(clock_i), .reset_i(reset_i),
      .clock_source_select_fuses_i(sel), .startup_time_fuses_i(start_fuses),
      .divide_by_eight_fuse_i(div_fuse), .ext_reset_hold_i(ext_hold),
      .wake_i(wake), .deep_sleep_i(deep_sleep), .core_halt_i(core_halt),
      .periph_halt_i(periph_halt), .conv_halt_i(conv_halt),
      .watchdog_tick_i(wd_tick), .osc_tick_i(osc_tick),
      .async_tick_i(async_tick), .internal_reset_o(int_reset),
      .source_o(source), .source_valid_o(valid), .core_en_o(core_en),
      .periph_en_o(periph_en), .progmem_en_o(), .async_en_o(),
      .conv_en_o(conv_en));
   osc_source_model i_osc_source_model (.clock_i(clock_i),
      .watchdog_tick_o(wd_tick), .osc_tick_o(osc_tick),
      .async_tick_o(async_tick));
   always #5 clock_i = ~clock_i;
   // Compare and report
   task automatic chk(input string what, input logic [15:0] got,
      input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Full start-up; osc ticks during time-out must not count
   task automatic startup(input logic [3:0] s, input logic [1:0] t,
      input int wd, input int osc);
      sel = s;
      start_fuses = t;
      ext_hold = 1'b1;
      tick(3);
      chk("reset held", 16'(int_reset), 16'h1);
      ext_hold = 1'b0;
      tick(2);
      if (wd > 0) begin
         i_osc_source_model.send_wd(wd - 1);
         i_osc_source_model.send_osc(osc);
         chk("reset in time-out", 16'(int_reset), 16'h1);
         i_osc_source_model.send_wd(1);
      end
      i_osc_source_model.send_osc(osc - 1);
      chk("reset in count", 16'(int_reset), 16'h1);
      i_osc_source_model.send_osc(1);
      chk("reset released", 16'(int_reset), 16'h0);
   endtask
   // Count enables over a 32-tick osc burst; 70 cycles flush the pipe
   task automatic en_check(input logic [15:0] c, p, v);
      logic [15:0] nc = 16'h0, np = 16'h0, nv = 16'h0;
      tick(4);
      fork
         i_osc_source_model.send_osc(32);
         repeat (70) begin
            tick(1);
            nc = nc + 16'(core_en);
            np = np + 16'(periph_en);
            nv = nv + 16'(conv_en);
         end
      join
      chk("core enables", nc, c);
      chk("periph enables", np, p);
      chk("conv enables", nv, v);
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard, about ten percent over the expected run
   initial begin
      #950000;
      num_errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      tick(16);
      reset_i = 1'b0;
      startup(SEL_RC_CAL, 2'h2, 8192, 6);
      en_check(16'h4, 16'h4, 16'h4);
      div_fuse = 1'b1;
      en_check(16'h20, 16'h20, 16'h20);
      core_halt = 1'b1;
      en_check(16'h0, 16'h20, 16'h20);
      periph_halt = 1'b1;
      en_check(16'h0, 16'h0, 16'h20);
      {core_halt, periph_halt, conv_halt} = 3'b001;
      en_check(16'h20, 16'h20, 16'h0);
      conv_halt = 1'b0;
      startup(SEL_EXT_CLOCK, 2'h0, 0, 6);
      deep_sleep = 1'b1;
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      tick(1);
      chk("reset on wake", 16'(int_reset), 16'h1);
      i_osc_source_model.send_osc(5);
      chk("wake count", 16'(int_reset), 16'h1);
      i_osc_source_model.send_osc(1);
      chk("wake release", 16'(int_reset), 16'h0);
      deep_sleep = 1'b0;
      startup(SEL_RC_128K, 2'h1, 512, 6);
      startup(4'hE, 2'h2, 0, 1024);
      startup(4'h4, 2'h0, 0, 32768);
      for (int i = 0; i < 16; i++) begin
         sel = 4'(i);
         tick(2);
         chk("source", 16'(source), 16'(kinds[i]));
         chk("valid", 16'(valid), 16'(i != 1));
      end
      end_of_test();
   end
endmodule

//--- testbench/osc_source_model.sv
// Oscillator, watchdog and async timer tick sources.
// Assumes ticks are sampled on rising edges of clock_i.
`timescale 1ns/10ps
module osc_source_model (
   input wire logic clock_i, // System clock
   output logic watchdog_tick_o, // Watchdog tick
   output logic osc_tick_o, // Oscillator tick
   output logic async_tick_o // Async timer tick
);
   logic [1:0] phase_reg = 2'h0; // Async divider
   initial watchdog_tick_o = 1'b0;
   initial osc_tick_o = 1'b0;
   // Async source runs free, one pulse in four
   always @(posedge clock_i) begin
      phase_reg <= #1 phase_reg + 2'h1;
   end
   assign async_tick_o = (phase_reg == 2'h0);
   // Osc stands still between bursts; idle cycle between pulses
   task automatic send_osc(input int n);
      repeat (n) begin
         @(posedge clock_i) #1 osc_tick_o = 1'b1;
         @(posedge clock_i) #1 osc_tick_o = 1'b0;
      end
   endtask
   // Watchdog pulses on the same spacing
   task automatic send_wd(input int n);
      repeat (n) begin
         @(posedge clock_i) #1 watchdog_tick_o = 1'b1;
         @(posedge clock_i) #1 watchdog_tick_o = 1'b0;
      end
   endtask
endmodule
